/* File: src/iprc_top.sv */
// Interrupt priority, watchdog, clock monitor and reset pin control.
`timescale 1ns/1ps
`default_nettype none
module iprc_top #(
  parameter int WD_SHIFT = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic ext_irq_n,
  input wire logic nonmaskable_pin_request_n,
  input wire logic [6:0] src_req,
  input wire logic osc_tick,
  input wire logic stop_req,
  input wire logic wake,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic sys_rst_n,
  output logic cpu_run,
  input wire iprc_pkg::iprc_ctx_t ctx,
  output iprc_pkg::iprc_seq_t seq
);
  typedef enum logic [4:0] {
    S_BOOT = 5'h01,
    S_IDLE = 5'h02,
    S_STK = 5'h04,
    S_VEC = 5'h08,
    S_SVC = 5'h10
  } iprc_sq_t;
  typedef enum logic [3:0] {
    R_IDLE = 4'h1,
    R_DRIVE = 4'h2,
    R_WAIT = 4'h4,
    R_HOLD = 4'h8
  } iprc_rs_t;
  typedef struct packed {
    logic irq_edge_select;
    logic ext_irq_connect;
    logic stop_exit_delay_en;
    logic edge_wr;
    logic dly_wr;
    logic spec_seen;
    logic [7:0] top;
    logic wd_en;
    logic wd_win;
    logic [2:0] wd_rate;
    logic cm_en;
    logic [2:0] rti_rate;
    logic rti_flag;
    logic wd_armed;
    logic [23:0] wd_cnt;
    logic [7:0] cm_cnt;
    logic [12:0] stp_cnt;
    logic run;
    logic stopping;
    logic irq_lat;
    logic irq_prev;
    iprc_rs_t rs;
    logic [4:0] rp_cnt;
    logic [1:0] cause;
    iprc_sq_t sq;
    logic [2:0] step;
    logic [7:0] vec;
    logic xv;
    logic [7:0] boot_vec;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic oe;
    logic sys_rst_n;
    iprc_pkg::iprc_seq_t so;
  } iprc_st_t;

  iprc_st_t s;
  iprc_st_t n;

  // Values after any reset, also reloaded on internal and pin resets.
  function automatic iprc_st_t dflt();
    iprc_st_t d;
    d = '0;
    d.ext_irq_connect = 1'b1;
    d.top = iprc_pkg::TOP_PRI_RST;
    d.stop_exit_delay_en = 1'b1;
    d.wd_en = 1'b1;
    d.wd_rate = iprc_pkg::WD_RATE_RST;
    d.run = 1'b1;
    d.rs = R_IDLE;
    d.sq = S_BOOT;
    d.boot_vec = iprc_pkg::VEC_RESET;
    d.sys_rst_n = 1'b1;
    return d;
  endfunction

  // Watchdog period for a rate selection.
  function automatic logic [23:0] wd_per(input logic [2:0] r);
    return 24'h000001 << (WD_SHIFT + int'(r));
  endfunction

  // Vector low byte of a maskable source index.
  function automatic logic [7:0] idx_vec(input logic [2:0] i);
    return iprc_pkg::VEC_HI - {4'h0, i, 1'b0};
  endfunction

  // Winning index: the promoted source if pending, else the lowest.
  function automatic logic [2:0] pick(input logic [7:0] p,
                                      input logic [7:0] t);
    logic [2:0] ti;
    logic [2:0] w;
    ti = 3'h0;
    w = 3'h0;
    if (t <= iprc_pkg::VEC_HI && t >= iprc_pkg::VEC_LO && !t[0]) begin
      ti = 3'((iprc_pkg::VEC_HI - t) >> 1);
    end
    for (int k = 7; k >= 0; k--) begin
      if (p[k]) begin
        w = 3'(k);
      end
    end
    if (p[ti]) begin
      w = ti;
    end
    return w;
  endfunction

  logic irq_req;
  logic [7:0] pend;
  logic nmi_req;
  logic any_req;
  logic [7:0] idx;
  logic wr;
  logic [7:0] wb;
  logic [23:0] per;
  logic wd_fail;
  logic cm_fail;
  iprc_st_t keep;

  // Request vector: bit 0 is the external pin, the rest are peripherals.
  always_comb begin
    if (!s.ext_irq_connect) begin
      irq_req = 1'b0;
    end else if (s.irq_edge_select) begin
      irq_req = s.irq_lat;
    end else begin
      irq_req = !ext_irq_n;
    end
    pend = {src_req, irq_req};
    nmi_req = !nonmaskable_pin_request_n && !ctx.x_mask;
    any_req = nmi_req || (!ctx.i_mask && |pend);
    idx = paddr[9:2];
    wr = psel && penable && pwrite && s.pready && !s.pslverr;
    wb = pwdata[7:0];
    per = wd_per(s.wd_rate);
  end

  // Next state of the whole block.
  always_comb begin
    n = s;
    wd_fail = 1'b0;
    cm_fail = 1'b0;
    keep = s;
    n.so = '0;

    // Register bus: zero wait, answer set up during the setup cycle.
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    n.prdata = '0;
    if (psel && !penable) begin
      n.pslverr = paddr[1:0] != 2'h0;
      case (idx)
        iprc_pkg::IDX_PIN_CTL:
          n.prdata[7:5] = {s.irq_edge_select, s.ext_irq_connect,
                           s.stop_exit_delay_en};
        iprc_pkg::IDX_TOP_PRI: n.prdata[7:0] = s.top;
        iprc_pkg::IDX_WD_CTL:
          n.prdata[9:0] = {s.rti_flag, s.rti_rate, s.cm_en, s.wd_win,
                           s.wd_en, s.wd_rate};
        iprc_pkg::IDX_WD_SVC: n.prdata = '0;
        iprc_pkg::IDX_RST_STAT: n.prdata[1:0] = s.cause;
        default: n.pslverr = 1'b1;
      endcase
    end

    // Pin control writes; special modes discard only the first edge select write.
    if (wr && idx == iprc_pkg::IDX_PIN_CTL) begin
      n.ext_irq_connect = wb[iprc_pkg::CONN_BIT];
      if (special_mode) begin
        n.spec_seen = 1'b1;
        if (s.spec_seen) begin
          n.irq_edge_select = wb[iprc_pkg::EDGE_BIT];
        end
      end else if (!s.edge_wr) begin
        n.edge_wr = 1'b1;
        n.irq_edge_select = wb[iprc_pkg::EDGE_BIT];
      end
      if (special_mode || !s.dly_wr) begin
        n.dly_wr = 1'b1;
        n.stop_exit_delay_en = wb[iprc_pkg::DLY_BIT];
      end
    end
    if (wr && idx == iprc_pkg::IDX_TOP_PRI && ctx.i_mask) begin
      n.top = wb;
    end
    if (wr && idx == iprc_pkg::IDX_WD_CTL) begin
      n.wd_rate = pwdata[2:0];
      n.wd_en = pwdata[3];
      n.wd_win = pwdata[4];
      n.cm_en = pwdata[5];
      n.rti_rate = pwdata[8:6];
    end

    // Falling edge latch, cleared when its vector is fetched.
    n.irq_prev = ext_irq_n;
    if (s.irq_prev && !ext_irq_n) begin
      n.irq_lat = 1'b1;
    end

    // Watchdog counts while enabled and the core runs.
    if (s.wd_en && s.run && s.rs == R_IDLE) begin
      n.wd_cnt = s.wd_cnt + 24'h000001;
      if (s.wd_cnt >= per - 24'h000001) begin
        wd_fail = 1'b1;
      end
      if (wr && idx == iprc_pkg::IDX_WD_SVC) begin
        if (s.wd_win && s.wd_cnt < per - (per >> 2)) begin
          wd_fail = 1'b1;
        end
        if (wb == iprc_pkg::WD_KEY1) begin
          n.wd_armed = 1'b1;
        end else if (wb == iprc_pkg::WD_KEY2 && s.wd_armed) begin
          n.wd_armed = 1'b0;
          n.wd_cnt = '0;
        end else begin
          wd_fail = 1'b1;
        end
      end
    end

    // clock monitor
    // A stopped oscillator in stop mode is expected, so watch only in run.
    if (osc_tick || !s.cm_en || !s.run) begin
      n.cm_cnt = '0;
    end else if (s.rs == R_IDLE) begin
      n.cm_cnt = s.cm_cnt + 8'h01;
      if (s.cm_cnt >= iprc_pkg::CLKMON_LIMIT - 8'h01) begin
        cm_fail = 1'b1;
      end
    end

    // Stop mode entry and exit.
    if (stop_req && s.run) begin
      n.run = 1'b0;
    end else if (!s.run && !s.stopping && wake) begin
      if (s.stop_exit_delay_en) begin
        n.stopping = 1'b1;
        n.stp_cnt = '0;
      end else begin
        n.run = 1'b1;
      end
    end else if (s.stopping && osc_tick) begin
      n.stp_cnt = s.stp_cnt + 13'h0001;
      if (s.stp_cnt == iprc_pkg::STOP_DLY_CYC - 13'h0001) begin
        n.stopping = 1'b0;
        n.run = 1'b1;
      end
    end

    // Interrupt entry sequencer.
    case (s.sq)
      S_BOOT: begin
        if (s.rs == R_IDLE && s.sys_rst_n) begin
          n.so.set_i = 1'b1;
          n.so.set_x = 1'b1;
          n.so.set_stop_dis = 1'b1;
          n.so.vec_fetch = 1'b1;
          n.so.vec_lo = s.boot_vec;
          n.sq = S_IDLE;
        end
      end
      S_IDLE: begin
        if (ctx.instr_done && any_req && s.run) begin
          n.xv = nmi_req;
          n.vec = nmi_req ? iprc_pkg::VEC_NMI : idx_vec(pick(pend, s.top));
          n.step = '0;
          n.sq = S_STK;
        end
      end
      S_STK: begin
        n.so.stk_we = 1'b1;
        n.so.stk_wide = 1'b1;
        n.step = s.step + 3'h1;
        case (s.step)
          3'h0: begin
            n.so.stk_addr = ctx.sp - iprc_pkg::OFS_RET;
            n.so.stk_data = ctx.ret;
          end
          3'h1: begin
            n.so.stk_addr = ctx.sp - iprc_pkg::OFS_Y;
            n.so.stk_data = ctx.y;
          end
          3'h2: begin
            n.so.stk_addr = ctx.sp - iprc_pkg::OFS_X;
            n.so.stk_data = ctx.x;
          end
          3'h3: begin
            n.so.stk_addr = ctx.sp - iprc_pkg::OFS_D;
            n.so.stk_data = ctx.d;
          end
          default: begin
            n.so.stk_wide = 1'b0;
            n.so.stk_addr = ctx.sp - iprc_pkg::OFS_CCR;
            n.so.stk_data = {8'h00, ctx.condition_code_reg};
            n.sq = S_VEC;
          end
        endcase
      end
      S_VEC: begin
        n.so.set_i = 1'b1;
        n.so.set_x = s.xv;
        n.so.vec_fetch = 1'b1;
        n.so.vec_lo = s.vec;
        // A new falling edge in the fetch cycle wins over the clear.
        if (s.vec == iprc_pkg::VEC_HI && !(s.irq_prev && !ext_irq_n)) begin
          n.irq_lat = 1'b0;
        end
        n.sq = S_SVC;
      end
      S_SVC: begin
        if (ctx.rti_req) begin
          if (nmi_req || |pend) begin
            n.xv = nmi_req;
            n.vec = nmi_req ? iprc_pkg::VEC_NMI : idx_vec(pick(pend, s.top));
            n.sq = S_VEC;
          end else begin
            n.so.resume = 1'b1;
            n.sq = S_IDLE;
          end
        end
      end
      default: n.sq = S_IDLE;
    endcase

    // Reset pin sequencing and cause discrimination.
    case (s.rs)
      R_DRIVE: begin
        n.rp_cnt = s.rp_cnt + 5'h01;
        if (s.rp_cnt == iprc_pkg::RST_DRIVE_CYC - 5'h01) begin
          n.oe = 1'b0;
          n.rp_cnt = '0;
          n.rs = R_WAIT;
        end
      end
      R_WAIT: begin
        n.rp_cnt = s.rp_cnt + 5'h01;
        if (s.rp_cnt == iprc_pkg::RST_SETTLE_CYC - 5'h01) begin
          if (!rst_pin_i) begin
            n.cause = iprc_pkg::CAUSE_EXT;
            n.boot_vec = iprc_pkg::VEC_RESET;
            n.rs = R_HOLD;
          end else begin
            n.sys_rst_n = 1'b1;
            n.rs = R_IDLE;
          end
        end
      end
      R_HOLD: begin
        if (rst_pin_i) begin
          n.sys_rst_n = 1'b1;
          n.rs = R_IDLE;
        end
      end
      default: n.rs = R_IDLE;
    endcase

    // Any reset reloads defaults but lets the bus answer finish.
    if (s.rs == R_IDLE && (wd_fail || cm_fail || !rst_pin_i)) begin
      keep = n;
      n = dflt();
      n.pready = keep.pready;
      n.pslverr = keep.pslverr;
      n.prdata = keep.prdata;
      n.irq_prev = keep.irq_prev;
      n.sys_rst_n = 1'b0;
      if (!rst_pin_i) begin
        n.cause = iprc_pkg::CAUSE_EXT;
        n.rs = R_HOLD;
      end else begin
        n.oe = 1'b1;
        n.rs = R_DRIVE;
        n.cause = cm_fail ? iprc_pkg::CAUSE_CLKMON : iprc_pkg::CAUSE_WDOG;
        n.boot_vec = cm_fail ? iprc_pkg::VEC_CLKMON : iprc_pkg::VEC_WDOG;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= dflt();
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = s.oe;
  assign sys_rst_n = s.sys_rst_n;
  assign cpu_run = s.run;
  assign seq = s.so;

  level_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!s.irq_edge_select && s.ext_irq_connect && !ext_irq_n) |-> irq_req)
    else $error("Low level not recognised in level mode.");
  edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == iprc_pkg::IDX_PIN_CTL && !special_mode && s.edge_wr)
    |=> $stable(s.irq_edge_select))
    else $error("Edge select changed by a second write.");
  conn_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.ext_irq_connect |-> !irq_req)
    else $error("Disconnected pin still requests.");
  stop_nodly_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!s.run && !s.stopping && wake && !s.stop_exit_delay_en && !stop_req
     && s.rs == R_IDLE) |=> s.run)
    else $error("Stop exit without delay did not resume.");
  top_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == iprc_pkg::IDX_TOP_PRI && !ctx.i_mask && s.rs == R_IDLE)
    |=> $stable(s.top))
    else $error("Priority written with mask clear.");
  default_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((s.top > iprc_pkg::VEC_HI || s.top < iprc_pkg::VEC_LO || s.top[0])
     && pend[0]) |-> pick(pend, s.top) == 3'h0)
    else $error("External pin not default top priority.");
  pin_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.oe) |-> s.oe ##16 !s.oe ##8 s.rs != R_WAIT)
    else $error("Reset pin drive or sample timing wrong.");
  bad_key_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == iprc_pkg::IDX_WD_SVC && s.wd_en && s.run
     && s.rs == R_IDLE && rst_pin_i && wb != iprc_pkg::WD_KEY1
     && wb != iprc_pkg::WD_KEY2) |=> (s.rs == R_DRIVE && !s.sys_rst_n))
    else $error("Bad watchdog key did not reset.");
  ccr_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.so.stk_we && !s.so.stk_wide) |=> (s.so.set_i && s.so.vec_fetch))
    else $error("Mask not set after condition codes stacked.");
  chain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.sq == S_SVC && ctx.rti_req && |pend && s.rs == R_IDLE && rst_pin_i)
    |=> s.sq == S_VEC ##1 s.so.vec_fetch && !s.so.stk_we)
    else $error("Pending request at return was restacked.");
endmodule // iprc_top
`default_nettype wire

/* File: src/iprc_pkg.sv */
// Constants and carrier types of the interrupt, priority and reset control.
// Overview of operation
// - Edge select 1 takes falling pin edges; 0 takes a low level.
// - Edge select writes once normally; special modes drop the first write.
// - Connect bit gates the external pin into interrupt logic, always writable.
// - Stop delay 1 waits 4096 oscillator cycles before resuming; 0 none.
// - Stop delay bit writes once normally, freely in special modes.
// - Top priority register is written only while the global mask is set.
// - A source's vector low byte there makes it top maskable priority.
// - Unimplemented or above F2 values make the external pin top priority.
// - Reset loads F2 and selects level recognition for the pin.
// - Internal reset drives pin low 16 cycles, samples 8 later.
// - Watchdog is serviced only by 55 then AA to its service register.
// - Other values, broken order or expiry cause a watchdog reset.
// - Windowed mode accepts service only in the last quarter period.
// - Enabled clock monitor resets when the clock stops too long.
// - Pin and power reset share a vector; watchdog and monitor own one.
// - Reset enables watchdog at longest rate, monitor off, stop delay set.
// - After reset both masks and stop disable are set, vector fetched.
// - Requests are answered only when the current instruction completes.
// - Entry stacks return, Y, X, B:A and codes at SP-2 to SP-9.
// - Then global mask, and pin mask when pending, set; vector fetched.
// - A request pending at return skips unstack and restack.
package iprc_pkg;
  localparam logic [7:0] IDX_WD_CTL = 8'h16;
  localparam logic [7:0] IDX_WD_SVC = 8'h17;
  localparam logic [7:0] IDX_RST_STAT = 8'h18;
  localparam logic [7:0] IDX_PIN_CTL = 8'h1E;
  localparam logic [7:0] IDX_TOP_PRI = 8'h1F;
  localparam int EDGE_BIT = 7;
  localparam int CONN_BIT = 6;
  localparam int DLY_BIT = 5;
  localparam logic [7:0] TOP_PRI_RST = 8'hF2;
  localparam logic [7:0] VEC_HI = 8'hF2;
  localparam logic [7:0] VEC_LO = 8'hE4;
  localparam logic [7:0] VEC_RESET = 8'hFE;
  localparam logic [7:0] VEC_CLKMON = 8'hFC;
  localparam logic [7:0] VEC_WDOG = 8'hFA;
  localparam logic [7:0] VEC_NMI = 8'hF4;
  localparam logic [7:0] WD_KEY1 = 8'h55;
  localparam logic [7:0] WD_KEY2 = 8'hAA;
  localparam logic [2:0] WD_RATE_RST = 3'h7;
  localparam logic [4:0] RST_DRIVE_CYC = 5'h10;
  localparam logic [4:0] RST_SETTLE_CYC = 5'h08;
  localparam logic [12:0] STOP_DLY_CYC = 13'h1000;
  localparam logic [7:0] CLKMON_LIMIT = 8'h40;
  localparam logic [15:0] OFS_RET = 16'h0002;
  localparam logic [15:0] OFS_Y = 16'h0004;
  localparam logic [15:0] OFS_X = 16'h0006;
  localparam logic [15:0] OFS_D = 16'h0008;
  localparam logic [15:0] OFS_CCR = 16'h0009;
  localparam logic [1:0] CAUSE_EXT = 2'h0;
  localparam logic [1:0] CAUSE_CLKMON = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;

  // Register file of the core, offered at interrupt entry.
  typedef struct packed {
    logic [15:0] sp;
    logic [15:0] ret;
    logic [15:0] y;
    logic [15:0] x;
    logic [15:0] d;
    logic [7:0] condition_code_reg;
    logic i_mask;
    logic x_mask;
    logic instr_done;
    logic rti_req;
  } iprc_ctx_t;

  // Commands from the entry sequencer to the core.
  typedef struct packed {
    logic stk_we;
    logic stk_wide;
    logic [15:0] stk_addr;
    logic [15:0] stk_data;
    logic vec_fetch;
    logic [7:0] vec_lo;
    logic set_i;
    logic set_x;
    logic set_stop_dis;
    logic resume;
  } iprc_seq_t;
endpackage

/* File: bench/iprc_core_model.sv */
// Behavioural core model that offers registers and logs entry traffic.
`timescale 1ns/1ps
`default_nettype none
module iprc_core_model (
  input wire logic pclk,
  input wire iprc_pkg::iprc_seq_t seq,
  input wire logic rti,
  input wire logic cli,
  output var iprc_pkg::iprc_ctx_t ctx
);
  logic [15:0] stk_a [8];
  logic [15:0] stk_d [8];
  logic [7:0] last_vec = 8'h00;
  logic vec_tgl = 1'h0;
  logic i_r = 1'h1;
  logic x_r = 1'h1;
  logic [1:0] ph = 2'h0;
  int n_stk = 0;
  int n_res = 0;
  logic stop_dis = 1'h0;

  // Registers stay fixed so that stacked values are known in advance.
  always_comb begin
    ctx = '0;
    ctx.sp = 16'h0400;
    ctx.ret = 16'h1111;
    ctx.y = 16'h2222;
    ctx.x = 16'h3333;
    ctx.d = 16'h4444;
    ctx.condition_code_reg = 8'hC5;
    ctx.i_mask = i_r;
    ctx.x_mask = x_r;
    ctx.instr_done = (ph == 2'h2);
    ctx.rti_req = rti;
  end

  // Logs stacking and fetches; masks clear only when software says so.
  always @(posedge pclk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (seq.stk_we) begin
      stk_a[n_stk[2:0]] <= seq.stk_addr;
      stk_d[n_stk[2:0]] <= seq.stk_data;
      n_stk <= n_stk + 1;
    end
    if (seq.resume) n_res <= n_res + 1;
    if (seq.set_stop_dis) stop_dis <= 1'h1;
    if (seq.vec_fetch) begin
      last_vec <= seq.vec_lo;
      vec_tgl <= ~vec_tgl;
    end
    if (seq.set_i) i_r <= 1'h1;
    else if (cli) i_r <= 1'h0;
    if (seq.set_x) x_r <= 1'h1;
    else if (cli) x_r <= 1'h0;
  end
endmodule // iprc_core_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench of the interrupt, priority and reset control.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rst_pin_o, rst_pin_oe, sys_rst_n, cpu_run, err;
  logic special_mode = 1'h0;
  logic ext_irq_n = 1'h1;
  logic nmi_n = 1'h1;
  logic osc_tick = 1'h1;
  logic stop_req = 1'h0;
  logic wake = 1'h0;
  logic ext_rst_n = 1'h1;
  logic rti = 1'h0;
  logic cli = 1'h0;
  logic seen_oe = 1'h0;
  logic [6:0] src_req = 7'h00;
  wire logic rst_pin_i;
  iprc_pkg::iprc_ctx_t ctx;
  iprc_pkg::iprc_seq_t seq;
  int fail_count = 0;
  int n_compared = 0;

  always #4 pclk = ~pclk;
  // Reset line has a pull-up; the device or the bench may pull it low.
  assign rst_pin_i = rst_pin_oe ? rst_pin_o : ext_rst_n;
  always @(posedge pclk) if (rst_pin_oe === 1'h1) seen_oe <= 1'h1;

  iprc_top #(.WD_SHIFT(2)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .ext_irq_n(ext_irq_n),
    .nonmaskable_pin_request_n(nmi_n), .src_req(src_req),
    .osc_tick(osc_tick), .stop_req(stop_req), .wake(wake),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .sys_rst_n(sys_rst_n), .cpu_run(cpu_run), .ctx(ctx), .seq(seq));
  iprc_core_model core (.pclk(pclk), .seq(seq), .rti(rti), .cli(cli),
    .ctx(ctx));

  // Verdict and counts; every path that ends the run comes here.
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // Bounded wait; n returns the edges spent, a run-out ends the test.
  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (s !== v) begin
      chk(s, v, "wait ran out");
      stop_test();
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    wait_for(pready, 1'h1, 16, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e,
                        input string m);
    apb(1'h0, idx, 8'h00);
    chk(rd, e, m);
  endtask

  // One-cycle strobe: 0 cli, 1 rti, 2 stop_req, 3 wake.
  task automatic pulse(input int w);
    {wake, stop_req, rti, cli} <= 4'h1 << w;
    @(posedge pclk);
    {wake, stop_req, rti, cli} <= 4'h0;
    @(posedge pclk);
  endtask

  // Watchdog is switched off after reset so long tests do not expire.
  task automatic do_reset(input logic sm);
    presetn <= 1'h0;
    special_mode <= sm;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h1, iprc_pkg::IDX_WD_CTL, 8'h00);
  endtask

  task automatic t_defaults();
    do_reset(1'h0);
    rd_chk(iprc_pkg::IDX_PIN_CTL, 32'h60, "pin ctl");
    rd_chk(iprc_pkg::IDX_TOP_PRI, 32'hF2, "top pri");
    chk(core.last_vec, iprc_pkg::VEC_RESET, "boot vec");
    chk(core.i_r & core.x_r, 1, "masks");
    chk(core.stop_dis, 1, "stop disable");
    apb(1'h0, 8'h20, 8'h00);
    chk(err, 1, "unmapped");
    $display("defaults done");
  endtask

  // Normal then special mode; low bits always stay zero.
  task automatic t_pins();
    logic [7:0] w [6] = '{8'h9F, 8'h60, 8'h00, 8'h80, 8'h80, 8'h20};
    logic [7:0] e [6] = '{8'h80, 8'hC0, 8'h80, 8'h00, 8'h80, 8'h20};
    for (int k = 0; k < 6; k++) begin
      if (k % 3 == 0) do_reset(k == 3);
      apb(1'h1, iprc_pkg::IDX_PIN_CTL, w[k]);
      rd_chk(iprc_pkg::IDX_PIN_CTL, e[k], "pin ctl");
    end
    $display("pin control done");
  endtask

  task automatic t_prio();
    logic [15:0] o [5] = '{iprc_pkg::OFS_RET, iprc_pkg::OFS_Y,
      iprc_pkg::OFS_X, iprc_pkg::OFS_D, iprc_pkg::OFS_CCR};
    logic [15:0] d [5] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'hC5};
    int s0, n;
    do_reset(1'h0);
    apb(1'h1, iprc_pkg::IDX_TOP_PRI, 8'hEE);
    src_req <= 7'h03;
    s0 = core.n_stk;
    pulse(0);
    wait_for(core.vec_tgl, ~core.vec_tgl, 60, n);
    chk(core.last_vec, 8'hEE, "promoted");
    chk(core.n_stk - s0, 5, "stack count");
    for (int k = 0; k < 5; k++) begin
      chk(core.stk_a[3'(s0 + k)], 16'h0400 - o[k], "stk addr");
      n = (k == 4) ? 32'hFF : 32'hFFFF;
      chk(core.stk_d[3'(s0 + k)] & n, d[k], "stk data");
    end
    chk(core.i_r, 1, "mask at entry");
    chk(core.x_r, 0, "x mask kept");
    src_req <= 7'h01;
    s0 = core.n_stk;
    pulse(1);
    wait_for(core.vec_tgl, ~core.vec_tgl, 20, n);
    chk(core.last_vec, 8'hF0, "chained");
    chk(core.n_stk - s0, 0, "no restack");
    apb(1'h1, iprc_pkg::IDX_TOP_PRI, 8'hE5);
    ext_irq_n <= 1'h0;
    src_req <= 7'h40;
    pulse(1);
    wait_for(core.vec_tgl, ~core.vec_tgl, 20, n);
    chk(core.last_vec, 8'hF2, "pin default");
    nmi_n <= 1'h0;
    pulse(1);
    wait_for(core.vec_tgl, ~core.vec_tgl, 20, n);
    chk(core.last_vec, iprc_pkg::VEC_NMI, "nmi chained");
    chk(core.x_r, 1, "x mask set");
    nmi_n <= 1'h1;
    ext_irq_n <= 1'h1;
    src_req <= 7'h00;
    s0 = core.n_res;
    pulse(1);
    pulse(0);
    apb(1'h1, iprc_pkg::IDX_TOP_PRI, 8'hF0);
    rd_chk(iprc_pkg::IDX_TOP_PRI, 32'hE5, "unmasked write");
    // Edge mode: a pin still held low after its fetch must not chain.
    apb(1'h1, iprc_pkg::IDX_PIN_CTL, 8'hC0);
    ext_irq_n <= 1'h0;
    wait_for(core.vec_tgl, ~core.vec_tgl, 40, n);
    chk(core.last_vec, 8'hF2, "edge entry");
    pulse(1);
    pulse(0);
    chk(core.n_res - s0, 2, "resumes");
    ext_irq_n <= 1'h1;
    $display("priority done");
  endtask

  // Waits for an internal reset to start, then checks it.
  task automatic int_rst(input logic [7:0] v, input logic [1:0] c);
    int n;
    wait_for(rst_pin_oe, 1'h1, 300, n);
    wait_for(rst_pin_oe, 1'h0, 40, n);
    chk(n, 16, "pin drive");
    wait_for(sys_rst_n, 1'h1, 40, n);
    repeat (4) @(posedge pclk);
    chk(core.last_vec, v, "reset vec");
    rd_chk(iprc_pkg::IDX_RST_STAT, {30'h0, c}, "cause");
  endtask

  task automatic t_wdog();
    int n;
    do_reset(1'h0);
    apb(1'h1, iprc_pkg::IDX_WD_CTL, 8'h0B);
    repeat (3) begin
      repeat (6) @(posedge pclk);
      apb(1'h1, iprc_pkg::IDX_WD_SVC, iprc_pkg::WD_KEY1);
      apb(1'h0, iprc_pkg::IDX_PIN_CTL, 8'h00);
      apb(1'h1, iprc_pkg::IDX_WD_SVC, iprc_pkg::WD_KEY2);
    end
    chk(seen_oe, 0, "serviced");
    apb(1'h1, iprc_pkg::IDX_WD_SVC, 8'h12);
    int_rst(iprc_pkg::VEC_WDOG, iprc_pkg::CAUSE_WDOG);
    apb(1'h1, iprc_pkg::IDX_WD_CTL, 8'h1B);
    apb(1'h1, iprc_pkg::IDX_WD_SVC, iprc_pkg::WD_KEY1);
    int_rst(iprc_pkg::VEC_WDOG, iprc_pkg::CAUSE_WDOG);
    apb(1'h1, iprc_pkg::IDX_WD_CTL, 8'h20);
    osc_tick <= 1'h0;
    int_rst(iprc_pkg::VEC_CLKMON, iprc_pkg::CAUSE_CLKMON);
    osc_tick <= 1'h1;
    ext_rst_n <= 1'h0;
    repeat (40) @(posedge pclk);
    chk(sys_rst_n, 0, "held");
    ext_rst_n <= 1'h1;
    wait_for(sys_rst_n, 1'h1, 40, n);
    repeat (4) @(posedge pclk);
    chk(core.last_vec, iprc_pkg::VEC_RESET, "pin vec");
    rd_chk(iprc_pkg::IDX_RST_STAT, 32'h0, "cause");
    rd_chk(iprc_pkg::IDX_WD_CTL, 32'h0F, "wd ctl");
    $display("reset sources done");
  endtask

  task automatic t_stop();
    int n;
    do_reset(1'h0);
    for (int k = 0; k < 2; k++) begin
      pulse(2);
      chk(cpu_run, 0, "stopped");
      pulse(3);
      wait_for(cpu_run, 1'h1, 5000, n);
      chk(k == 0 ? n > 4092 && n < 4098 : n < 2, 1, "exit delay");
      apb(1'h1, iprc_pkg::IDX_PIN_CTL, 8'h40);
    end
    $display("stop done");
  endtask

  initial begin
    t_defaults();
    t_pins();
    t_prio();
    t_wdog();
    t_stop();
    stop_test();
  end

  // A hang is cut short here.
  initial begin
    repeat (60000) @(posedge pclk);
    chk(0, 1, "run limit");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
